// ==== include/pllcp_pkg.sv ====
// Package for the synthesizer divider programming port.
// Functional notes
// - Serial data arrives most significant bit first and shifts in that order.
// - Enhancement write low: each serial clock rise shifts into the shift word.
// - Enhancement write high: serial clock rises shift into enhancement byte.
// - Serial mode: counters from primary if select is 1, else secondary.
// - Parallel mode: counters from primary if select is 1, else secondary.
// - Direct mode: prescaler enable is active low; high bypasses prescaler.
// - Parallel enhancement strobe rise captures all eight bus bits.
// - Main upper strobe rise loads bus 3:0 into reference 5:4, main 8:7.
// - Main lower strobe rise loads prescaler bit and main 6:0.
// - Swallow strobe rise loads reference 3:0 and swallow 3:0.
// - Hop strobe rise copies primary word into secondary word, except in direct mode.
// - Bus mode 1 selects direct; else serial select picks serial or parallel.
// - Direct mode swallow value comes from four strap pins, bit0 lowest.
// - Parallel bus is eight bits, bit0 lowest, shared by all strobes.
// - Shift only while load enable low; its rise in serial mode copies the shift word to primary and secondary.
// - Enhancement bits act only while enhancement mode input is low.
package pllcp_pkg;

  localparam int WORD_W    = 20;
  localparam int ENH_W     = 8;
  localparam int DATA_W    = 8;
  localparam int A_LSB     = 0;
  localparam int A_W       = 4;
  localparam int R_LSB     = 4;
  localparam int R_W       = 6;
  localparam int M_LSB     = 10;
  localparam int M_W       = 9;
  localparam int PRE_BIT   = 19;
  localparam int SYNC_N    = 3;
  localparam logic [WORD_W-1:0] WORD_RST = 20'h00000;
  localparam logic [ENH_W-1:0]  ENH_RST  = 8'h00;

  typedef enum logic [1:0] {
    PLLCP_SERIAL,
    PLLCP_PARALLEL,
    PLLCP_DIRECT
  } pllcp_mode_t;

  typedef struct packed {
    logic              bus_mode;
    logic              serial_mode;
    logic              serial_frequency_select;
    logic              parallel_frequency_select;
    logic              enh_mode_n;
    logic              enh_write;
    logic              main_upper_write_strobe;
    logic              main_lower_write_strobe;
    logic              swallow_write_strobe;
    logic              hop_write_strobe;
    logic              serial_load;
    logic [DATA_W-1:0] data;
  } pllcp_pins_t;

  typedef struct packed {
    logic           prescaler_enable_n;
    logic [M_W-1:0] main;
    logic [R_W-1:0] ref_div;
    logic [A_W-1:0] swallow;
  } pllcp_straps_t;

  typedef struct packed {
    logic           prescaler_bypass;
    logic [M_W-1:0] main;
    logic [R_W-1:0] ref_div;
    logic [A_W-1:0] swallow;
  } pllcp_counters_t;

  localparam int PIN_W = $bits(pllcp_pins_t);
  localparam int SYN_W = $bits(pllcp_pins_t) + $bits(pllcp_straps_t);

endpackage

// ==== verilog/pllcp_port.sv ====
// Divider programming port: serial, parallel and strapped loading.
`timescale 1ns/1ps
module pllcp_port
  import pllcp_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            serial_clk,
  input  wire logic            sdata,
  input  wire pllcp_pins_t     pins,
  input  wire pllcp_straps_t   straps,
  output pllcp_counters_t      counters,
  output logic [ENH_W-1:0]     enhancement,
  output pllcp_mode_t          mode
);

  // ------------------------------------------------------------------
  // Functions.
  // ------------------------------------------------------------------
  function automatic pllcp_mode_t decode_mode(input logic bm,
                                              input logic sm);
    if (bm) begin
      return PLLCP_DIRECT;
    end
    return sm ? PLLCP_SERIAL : PLLCP_PARALLEL;
  endfunction

  function automatic pllcp_counters_t unpack_word(
      input logic [WORD_W-1:0] w);
    pllcp_counters_t c;
    c.prescaler_bypass = w[PRE_BIT];
    c.main             = w[M_LSB +: M_W];
    c.ref_div          = w[R_LSB +: R_W];
    c.swallow          = w[A_LSB +: A_W];
    return c;
  endfunction

  // ------------------------------------------------------------------
  // Serial clock domain shift registers.
  // ------------------------------------------------------------------
  logic [WORD_W-1:0] ser_word;
  logic [ENH_W-1:0]  ser_enh;

  always_ff @(posedge serial_clk) begin
    if (!pins.serial_load && !pins.enh_write) begin
      ser_word <= {ser_word[WORD_W-2:0], sdata};
    end
  end

  always_ff @(posedge serial_clk) begin
    if (!pins.serial_load && pins.enh_write) begin
      ser_enh <= {ser_enh[ENH_W-2:0], sdata};
    end
  end

  // ------------------------------------------------------------------
  // Pin synchronisers and edge filters.
  // ------------------------------------------------------------------
  logic [SYN_W-1:0] raw;
  logic [SYN_W-1:0] filt;
  logic [SYN_W-1:0] rise;
  logic [SYN_W-1:0] fall;

  assign raw = {straps, pins};

  for (genvar i = 0; i < SYN_W; i++) begin : g_sync
    logic [SYNC_N-1:0] stg;
    always_ff @(posedge clk) begin
      if (srst) begin
        stg <= '0;
      end else begin
        stg <= {stg[SYNC_N-2:0], raw[i]};
      end
    end
    always_ff @(posedge clk) begin
      if (srst) begin
        filt[i] <= 1'b0;
        rise[i] <= 1'b0;
        fall[i] <= 1'b0;
      end else begin
        rise[i] <= 1'b0;
        fall[i] <= 1'b0;
        if (stg[1] == stg[2]) begin
          filt[i] <= stg[2];
          rise[i] <= stg[2] & ~filt[i];
          fall[i] <= ~stg[2] & filt[i];
        end
      end
    end
  end

  pllcp_pins_t   pin_f;
  pllcp_pins_t   pin_r;
  pllcp_pins_t   pin_fl;
  pllcp_straps_t strap_f;

  assign pin_f   = pllcp_pins_t'(filt[PIN_W-1:0]);
  assign pin_r   = pllcp_pins_t'(rise[PIN_W-1:0]);
  assign pin_fl  = pllcp_pins_t'(fall[PIN_W-1:0]);
  assign strap_f = pllcp_straps_t'(filt[SYN_W-1:PIN_W]);

  // ------------------------------------------------------------------
  // Interface mode.
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      mode <= PLLCP_PARALLEL;
    end else begin
      mode <= decode_mode(pin_f.bus_mode, pin_f.serial_mode);
    end
  end

  logic in_serial;
  logic in_parallel;
  logic ser_done;

  assign in_serial   = (mode == PLLCP_SERIAL);
  assign in_parallel = (mode == PLLCP_PARALLEL);
  assign ser_done    = in_serial && pin_r.serial_load;

  // ------------------------------------------------------------------
  // Primary and secondary words.
  // ------------------------------------------------------------------
  logic [WORD_W-1:0] primary_divider_word;
  logic [WORD_W-1:0] secondary_word;

  always_ff @(posedge clk) begin
    if (srst) begin
      primary_divider_word <= WORD_RST;
    end else if (ser_done) begin
      primary_divider_word <= ser_word;
    end else if (in_parallel) begin
      if (pin_r.main_upper_write_strobe) begin
        primary_divider_word[R_LSB+4 +: 2] <= pin_f.data[3:2];
        primary_divider_word[M_LSB+7 +: 2] <= pin_f.data[1:0];
      end
      if (pin_r.main_lower_write_strobe) begin
        primary_divider_word[PRE_BIT]     <= pin_f.data[7];
        primary_divider_word[M_LSB +: 7]  <= pin_f.data[6:0];
      end
      if (pin_r.swallow_write_strobe) begin
        primary_divider_word[R_LSB +: 4]  <= pin_f.data[7:4];
        primary_divider_word[A_LSB +: A_W] <= pin_f.data[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      secondary_word <= WORD_RST;
    end else if (ser_done) begin
      secondary_word <= ser_word;
    end else if (!(mode == PLLCP_DIRECT) && pin_r.hop_write_strobe) begin
      secondary_word <= primary_divider_word;
    end
  end

  // ------------------------------------------------------------------
  // Enhancement byte.
  // ------------------------------------------------------------------
  logic [ENH_W-1:0] enhancement_control_byte;

  always_ff @(posedge clk) begin
    if (srst) begin
      enhancement_control_byte <= ENH_RST;
    end else if (in_serial && pin_fl.enh_write) begin
      enhancement_control_byte <= ser_enh;
    end else if (in_parallel && pin_r.enh_write) begin
      enhancement_control_byte <= pin_f.data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      enhancement <= ENH_RST;
    end else if (!pin_f.enh_mode_n && mode != PLLCP_DIRECT) begin
      enhancement <= enhancement_control_byte;
    end else begin
      enhancement <= ENH_RST;
    end
  end

  // ------------------------------------------------------------------
  // Counter values.
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      counters <= unpack_word(WORD_RST);
    end else begin
      unique case (mode)
        PLLCP_DIRECT: begin
          counters.prescaler_bypass <= strap_f.prescaler_enable_n;
          counters.main             <= strap_f.main;
          counters.ref_div          <= strap_f.ref_div;
          counters.swallow          <= strap_f.swallow;
        end
        PLLCP_SERIAL: begin
          counters <= unpack_word(pin_f.serial_frequency_select ?
                        primary_divider_word : secondary_word);
        end
        PLLCP_PARALLEL: begin
          counters <= unpack_word(pin_f.parallel_frequency_select ?
                        primary_divider_word : secondary_word);
        end
        default: begin
          counters <= unpack_word(WORD_RST);
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_par_strobe_only_swallow;
    in_parallel && pin_r.swallow_write_strobe &&
      !pin_r.main_upper_write_strobe && !pin_r.main_lower_write_strobe;
  endsequence

  sequence s_serial_load_end;
    ser_done ##1 1'b1;
  endsequence

  a_mode_direct_sel: assert property (
    pin_f.bus_mode |=> mode == PLLCP_DIRECT)
    else $error("Bus mode high did not select direct mode.");

  a_serial_msb_first: assert property (
    @(posedge serial_clk) disable iff (1'b0)
    (!pins.serial_load && !pins.enh_write) |=>
      ser_word[0] == $past(sdata) &&
      ser_word[WORD_W-1:1] === $past(ser_word[WORD_W-2:0]))
    else $error("Serial word did not shift msb first.");

  a_serial_fsel_prim: assert property (
    in_serial && pin_f.serial_frequency_select |=>
      counters == unpack_word($past(primary_divider_word)))
    else $error("Serial mode primary selection wrong.");

  a_serial_fsel_sec: assert property (
    in_serial && !pin_f.serial_frequency_select |=>
      counters == unpack_word($past(secondary_word)))
    else $error("Serial mode secondary selection wrong.");

  a_par_fsel_prim: assert property (
    in_parallel && pin_f.parallel_frequency_select |=>
      counters == unpack_word($past(primary_divider_word)))
    else $error("Parallel mode primary selection wrong.");

  a_serial_enh_load: assert property (
    in_serial && pin_fl.enh_write |=>
      enhancement_control_byte == $past(ser_enh))
    else $error("Serial enhancement byte not loaded.");

  a_par_fsel_sec: assert property (
    in_parallel && !pin_f.parallel_frequency_select |=>
      counters == unpack_word($past(secondary_word)))
    else $error("Parallel mode secondary selection wrong.");

  a_direct_prescaler: assert property (
    mode == PLLCP_DIRECT |=> counters.prescaler_bypass ==
      $past(strap_f.prescaler_enable_n))
    else $error("Direct prescaler bypass not from strap.");

  a_direct_swallow: assert property (
    mode == PLLCP_DIRECT |=> counters.swallow == $past(strap_f.swallow)
      && counters.main == $past(strap_f.main))
    else $error("Direct counters not from straps.");

  a_enh_par_write: assert property (
    in_parallel && pin_r.enh_write |=>
      enhancement_control_byte == $past(pin_f.data))
    else $error("Enhancement byte not captured from bus.");

  a_main_upper_load: assert property (
    in_parallel && pin_r.main_upper_write_strobe |=>
      primary_divider_word[M_LSB+7 +: 2] == $past(pin_f.data[1:0]) &&
      primary_divider_word[R_LSB+4 +: 2] == $past(pin_f.data[3:2]))
    else $error("Main upper strobe load wrong.");

  a_main_lower_load: assert property (
    in_parallel && pin_r.main_lower_write_strobe && !ser_done |=>
      primary_divider_word[PRE_BIT] == $past(pin_f.data[7]))
    else $error("Main lower strobe prescaler bit wrong.");

  a_swallow_only: assert property (
    s_par_strobe_only_swallow |=>
      primary_divider_word[A_LSB +: A_W] == $past(pin_f.data[3:0]) &&
      primary_divider_word[M_LSB +: M_W] ==
        $past(primary_divider_word[M_LSB +: M_W]))
    else $error("Swallow strobe load wrong or disturbed others.");

  a_hop_copy: assert property (
    !ser_done && mode != PLLCP_DIRECT && pin_r.hop_write_strobe |=>
      secondary_word == $past(primary_divider_word))
    else $error("Hop strobe did not copy primary word.");

  a_serial_transfer: assert property (
    s_serial_load_end |-> secondary_word == primary_divider_word)
    else $error("Serial load end did not transfer word.");

  a_enh_gate: assert property (
    pin_f.enh_mode_n |=> enhancement == ENH_RST)
    else $error("Enhancement bits active while disabled.");

endmodule

// ==== tb/pllcp_host.sv ====
// Host model that clocks serial words into the programming port.
`timescale 1ns/1ps
module pllcp_host (
  output logic serial_clk,
  output logic sdata
);

  // ----------------------------------------------------------------
  // Serial frame driver
  // ----------------------------------------------------------------
  // The clock stands low between frames; data falls to the pull-down level.
  initial begin
    serial_clk = 1'b0;
    sdata      = 1'b0;
  end

  task automatic shift_bit(input logic b);
    sdata = b;
    #6 serial_clk = 1'b1;
    #6 serial_clk = 1'b0;
  endtask

  task automatic shift_word(input logic [19:0] w);
    for (int i = 19; i >= 0; i--) begin
      shift_bit(w[i]);
    end
    sdata = 1'b0;
  endtask

  task automatic shift_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      shift_bit(b[i]);
    end
    sdata = 1'b0;
  endtask

endmodule

// ==== tb/pllcp_port_tb.sv ====
// Self-checking testbench for the divider programming port.
`timescale 1ns/1ps
module pllcp_port_tb;
  import pllcp_pkg::*;

  logic            clk;
  logic            srst;
  logic            serial_clk;
  logic            sdata;
  pllcp_pins_t     pins;
  pllcp_straps_t   straps;
  pllcp_counters_t counters;
  logic [7:0]      enhancement;
  pllcp_mode_t     mode;
  int              failures;
  int              samples_checked;

  // ----------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  pllcp_host host_i (
    .serial_clk (serial_clk),
    .sdata      (sdata)
  );

  pllcp_port pllcp_port_i (
    .clk         (clk),
    .srst        (srst),
    .serial_clk  (serial_clk),
    .sdata       (sdata),
    .pins        (pins),
    .straps      (straps),
    .counters    (counters),
    .enhancement (enhancement),
    .mode        (mode)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Polls a bounded number of cycles for the expected outputs.
  task automatic expect_out(input pllcp_counters_t c, input logic [7:0] e,
                            input pllcp_mode_t m);
    int k;
    k = 0;
    while (k < 30 && !(counters === c && enhancement === e && mode === m)) begin
      @(negedge clk);
      k++;
    end
    samples_checked++;
    if (!(counters === c && enhancement === e && mode === m)) begin
      failures++;
      $display("MISMATCH at %0t: counters %h enh %h mode %0d", $time,
               counters, enhancement, mode);
      finish_test();
    end
  endtask

  task automatic set_strobe(input int s, input logic v);
    case (s)
      0: pins.swallow_write_strobe = v;
      1: pins.main_lower_write_strobe = v;
      2: pins.main_upper_write_strobe = v;
      3: pins.hop_write_strobe = v;
      4: pins.enh_write = v;
      default: pins.serial_load = v;
    endcase
  endtask

  task automatic strobe(input int s, input logic [7:0] d);
    pins.data = d;
    idle(5);
    set_strobe(s, 1'b1);
    idle(5);
    set_strobe(s, 1'b0);
    idle(5);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    pins            = '0;
    straps          = '0;
    srst            = 1'b1;
    failures        = 0;
    samples_checked = 0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    expect_out('0, 8'h00, PLLCP_PARALLEL);
    pins.parallel_frequency_select = 1'b1;
    pins.enh_mode_n = 1'b1;
    strobe(0, 8'hA5);
    expect_out({1'b0, 9'h000, 6'h0A, 4'h5}, 8'h00, PLLCP_PARALLEL);
    strobe(1, 8'h9B);
    expect_out({1'b1, 9'h01B, 6'h0A, 4'h5}, 8'h00, PLLCP_PARALLEL);
    strobe(2, 8'hFE);
    expect_out({1'b1, 9'h11B, 6'h3A, 4'h5}, 8'h00, PLLCP_PARALLEL);
    pins.parallel_frequency_select = 1'b0;
    expect_out('0, 8'h00, PLLCP_PARALLEL);
    strobe(3, 8'h00);
    expect_out({1'b1, 9'h11B, 6'h3A, 4'h5}, 8'h00, PLLCP_PARALLEL);
    pins.enh_mode_n = 1'b0;
    strobe(4, 8'h3C);
    expect_out({1'b1, 9'h11B, 6'h3A, 4'h5}, 8'h3C, PLLCP_PARALLEL);
    pins.enh_mode_n = 1'b1;
    expect_out({1'b1, 9'h11B, 6'h3A, 4'h5}, 8'h00, PLLCP_PARALLEL);
    $display("parallel test done");
    pins.serial_mode = 1'b1;
    pins.serial_frequency_select = 1'b1;
    expect_out({1'b1, 9'h11B, 6'h3A, 4'h5}, 8'h00, PLLCP_SERIAL);
    host_i.shift_word(20'h6B2D9);
    strobe(5, 8'h00);
    expect_out(20'h6B2D9, 8'h00, PLLCP_SERIAL);
    pins.serial_frequency_select = 1'b0;
    idle(8);
    expect_out(20'h6B2D9, 8'h00, PLLCP_SERIAL);
    host_i.shift_word(20'h9A4E3);
    strobe(5, 8'h00);
    expect_out(20'h9A4E3, 8'h00, PLLCP_SERIAL);
    pins.enh_write = 1'b1;
    idle(5);
    host_i.shift_byte(8'hA6);
    idle(6);
    pins.enh_write = 1'b0;
    pins.enh_mode_n = 1'b0;
    expect_out(20'h9A4E3, 8'hA6, PLLCP_SERIAL);
    $display("serial test done");
    straps = {1'b1, 9'h1A5, 6'h2B, 4'h9};
    pins.bus_mode = 1'b1;
    expect_out({1'b1, 9'h1A5, 6'h2B, 4'h9}, 8'h00, PLLCP_DIRECT);
    straps.prescaler_enable_n = 1'b0;
    straps.swallow = 4'h6;
    expect_out({1'b0, 9'h1A5, 6'h2B, 4'h6}, 8'h00, PLLCP_DIRECT);
    $display("direct test done");
    finish_test();
  end

endmodule
